// ---- srse_top.sv ----
`timescale 1ns/1ns
module srse_top #(
    parameter int N = 8
) (
    // System clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         srst_i,
    // APB slave
    input  wire logic [7:0]   paddr_i,
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [31:0]  pwdata_i,
    output logic      [31:0]  prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    // Device pins
    input  wire logic         shift_clk_i,
    input  wire logic         async_clear_n_i,
    input  wire logic         serial_in_0_i,
    input  wire logic         serial_in_1_i,
    input  wire logic [N-1:0] parallel_io_i,
    output logic      [N-1:0] parallel_io_o,
    output logic      [N-1:0] parallel_io_oe_o,
    output logic              cascade_out_o
);
    logic [4:0]   ctrl_reg;
    logic [N-1:0] stage_reg;
    logic [N-1:0] next_val;
    logic [N-1:0] par_s;
    logic [3:0]   pins_s;
    logic         clk_s;
    logic         clr_n_s;
    logic         si0_s;
    logic         si1_s;
    logic         clk_d_reg;
    logic         clk_rise;
    logic         run_en_n;
    logic         shift_load;
    logic         sign_ext_n;
    logic         data_sel;
    logic         bus_drive_n;
    logic         load_sel;
    logic         oe_next;
    logic         oe_reg;
    logic [31:0]  prdata_reg;
    logic [31:0]  rd_next;
    logic         pready_reg;
    logic         pslverr_reg;
    logic         setup;
    logic         wr_done;

    // Address decode shared by error response and unmapped read check
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == srse_pkg::ADDR_CTRL) || (a == srse_pkg::ADDR_STAGES)
                 || (a == srse_pkg::ADDR_STATUS);
    endfunction

    // Pin synchronisers; bus terminals and control pins separately
    srse_sync #(
        .W       (N),
        .RST_VAL (srse_pkg::STAGE_RESET)
    ) u_par_sync (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .d_i       (parallel_io_i),
        .q_o       (par_s)
    );

    srse_sync #(
        .W       (4),
        .RST_VAL (4'h2)
    ) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .d_i       ({serial_in_1_i, serial_in_0_i, async_clear_n_i, shift_clk_i}),
        .q_o       (pins_s)
    );

    assign clk_s   = pins_s[0];
    assign clr_n_s = pins_s[1];
    assign si0_s   = pins_s[2];
    assign si1_s   = pins_s[3];

    // Device clock edge seen on the synchronised level
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            clk_d_reg <= 1'b0;
        end else begin
            clk_d_reg <= clk_s;
        end
    end

    assign clk_rise = clk_s && !clk_d_reg;

    assign run_en_n    = ctrl_reg[srse_pkg::CTRL_RUN_EN_N];
    assign shift_load  = ctrl_reg[srse_pkg::CTRL_SHIFT_LOAD];
    assign sign_ext_n  = ctrl_reg[srse_pkg::CTRL_SIGN_EXT_N];
    assign data_sel    = ctrl_reg[srse_pkg::CTRL_DATA_SEL];
    assign bus_drive_n = ctrl_reg[srse_pkg::CTRL_BUS_DRIVE_N];
    assign load_sel    = !run_en_n && !shift_load;

    srse_next #(
        .N (N)
    ) u_next (
        .stage_i         (stage_reg),
        .par_i           (par_s),
        .serial_in_0_i   (si0_s),
        .serial_in_1_i   (si1_s),
        .shift_or_load_i (shift_load),
        .sign_extend_n_i (sign_ext_n),
        .data_select_i   (data_sel),
        .next_o          (next_val)
    );

    // Stage chain
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            stage_reg <= srse_pkg::STAGE_RESET;
        end else if (!clr_n_s) begin
            stage_reg <= srse_pkg::STAGE_RESET;
        end else if (clk_rise && !run_en_n) begin
            stage_reg <= next_val;
        end
    end

    // Terminal drive, released for load or when bus_drive_n is high
    assign oe_next = !bus_drive_n && !load_sel;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= oe_next;
        end
    end

    assign parallel_io_o    = stage_reg;
    assign parallel_io_oe_o = {N{oe_reg}};
    assign cascade_out_o    = stage_reg[N-1];

    // APB: answer in the first cycle of the access phase, never stretched
    assign setup   = psel_i && !penable_i;
    assign wr_done = psel_i && penable_i && pready_reg && pwrite_i;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ctrl_reg <= srse_pkg::CTRL_RESET;
        end else if (wr_done && (paddr_i == srse_pkg::ADDR_CTRL)) begin
            ctrl_reg <= pwdata_i[srse_pkg::CTRL_W-1:0];
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        case (paddr_i)
            srse_pkg::ADDR_CTRL: begin
                rd_next[srse_pkg::CTRL_W-1:0] = ctrl_reg;
            end
            srse_pkg::ADDR_STAGES: begin
                rd_next[N-1:0] = stage_reg;
                rd_next[srse_pkg::STG_CASCADE] = stage_reg[N-1];
            end
            srse_pkg::ADDR_STATUS: begin
                rd_next[srse_pkg::STAT_OE] = oe_reg;
                rd_next[srse_pkg::STAT_CLR_N] = clr_n_s;
                rd_next[srse_pkg::STAT_CLK] = clk_s;
            end
            default: begin
                rd_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup && !is_mapped(paddr_i);
            if (setup && !pwrite_i) begin
                prdata_reg <= rd_next;
            end
        end
    end

    assign prdata_o  = prdata_reg;
    assign pready_o  = pready_reg;
    assign pslverr_o = pslverr_reg;

    // Checks
    load_capture_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_rise && load_sel && clr_n_s) |=> (stage_reg == $past(par_s)))
        else $error("parallel load did not capture the terminals");

    serial_pick_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_rise && !run_en_n && shift_load && sign_ext_n && clr_n_s)
        |=> (stage_reg[0] == $past(data_sel ? si1_s : si0_s)))
        else $error("wrong serial input entered the first stage");

    cascade_shift_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_rise && !run_en_n && shift_load && clr_n_s)
        |=> (cascade_out_o == $past(stage_reg[N-2])))
        else $error("cascade output did not take the seventh stage");

    sign_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_rise && !run_en_n && shift_load && !sign_ext_n && clr_n_s)
        |=> (stage_reg == {$past(stage_reg[N-2:0]), $past(stage_reg[0])}))
        else $error("sign extend did not repeat the first stage");

    shift_body_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_rise && !run_en_n && shift_load && clr_n_s)
        |=> (stage_reg[N-1:1] == $past(stage_reg[N-2:0])))
        else $error("stages did not move one place on shift");

    hold_stable_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (run_en_n && clr_n_s) |=> $stable(stage_reg))
        else $error("contents changed while held");

    edge_only_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (!clk_rise && clr_n_s) |=> $stable(stage_reg))
        else $error("contents changed without a device clock rise");

    clear_force_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !clr_n_s |=> (stage_reg == srse_pkg::STAGE_RESET) && !cascade_out_o)
        else $error("clear did not empty the stages");

    load_release_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        load_sel |=> (parallel_io_oe_o == '0))
        else $error("terminals driven during load");

    drive_off_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        bus_drive_n |=> (parallel_io_oe_o == '0))
        else $error("terminals driven while released");

    clear_load_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (load_sel && !clr_n_s) |=> (parallel_io_oe_o == '0) && (stage_reg == '0))
        else $error("load under clear drove terminals or kept data");

    readback_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (!bus_drive_n && !load_sel) |=> (parallel_io_oe_o == '1)
            && (parallel_io_o == stage_reg))
        else $error("stored bits not driven onto the terminals");

    cascade_load_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_rise && load_sel && clr_n_s) |=> (cascade_out_o == $past(par_s[N-1])))
        else $error("cascade output did not follow the loaded last bit");

    cascade_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (run_en_n && clr_n_s) |=> $stable(cascade_out_o))
        else $error("cascade output changed while held");

    release_shift_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_rise && !run_en_n && shift_load && bus_drive_n && clr_n_s)
        |=> (stage_reg[N-1:1] == $past(stage_reg[N-2:0])))
        else $error("shifting stopped while terminals released");

    read_stage_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (psel_i && !penable_i && !pwrite_i && (paddr_i == srse_pkg::ADDR_STAGES))
        |=> (prdata_o[N-1:0] == $past(stage_reg))
            && (prdata_o[srse_pkg::STG_CASCADE] == $past(cascade_out_o)))
        else $error("stage read did not return the contents");

    // Bus answer and reset checks
    ready_answer_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (psel_i && !penable_i) |=> pready_o)
        else $error("setup cycle not answered in the next cycle");

    ready_pulse_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        pready_o |=> !pready_o)
        else $error("ready stretched beyond one cycle");

    error_ready_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        pslverr_o |-> pready_o)
        else $error("error response without ready");

    ctrl_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (psel_i && penable_i && pready_o && pwrite_i && (paddr_i == srse_pkg::ADDR_CTRL))
        |=> (ctrl_reg == $past(pwdata_i[srse_pkg::CTRL_W-1:0])))
        else $error("control write did not land");

    unmapped_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (psel_i && !penable_i && !pwrite_i && !is_mapped(paddr_i))
        |=> pslverr_o && (prdata_o == 32'h0000_0000))
        else $error("unmapped read not refused");

    reset_value_a: assert property (@(posedge sys_clk_i)
        srst_i |=> (ctrl_reg == srse_pkg::CTRL_RESET) && (stage_reg == srse_pkg::STAGE_RESET)
            && !oe_reg && !pready_o)
        else $error("reset values not taken");
endmodule

// ---- srse_pkg.sv ----
package srse_pkg;
    // Register map, byte addresses on the APB
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STAGES = 8'h04;
    localparam logic [7:0]  ADDR_STATUS = 8'h08;

    // Control register fields
    localparam int          CTRL_W           = 5;
    localparam int          CTRL_RUN_EN_N    = 0;
    localparam int          CTRL_SHIFT_LOAD  = 1;
    localparam int          CTRL_SIGN_EXT_N  = 2;
    localparam int          CTRL_DATA_SEL    = 3;
    localparam int          CTRL_BUS_DRIVE_N = 4;
    // Hold, sign extend off, parallel terminals released
    localparam logic [4:0]  CTRL_RESET       = 5'h15;

    // Stage register read fields
    localparam int          STG_CASCADE = 8;

    // Status register fields
    localparam int          STAT_OE     = 0;
    localparam int          STAT_CLR_N  = 1;
    localparam int          STAT_CLK    = 2;

    // Stage count and reset values
    localparam int          STAGES      = 8;
    localparam logic [7:0]  STAGE_RESET = 8'h00;
    localparam int          SYNC_DEPTH  = 2;
endpackage

// ---- srse_sync.sv ----
`timescale 1ns/1ns
// Two-flop synchroniser for pins from outside the clock domain
module srse_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         srst_i,
    // Asynchronous level in, synchronised level out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            meta_reg <= RST_VAL;
            q_reg    <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            q_reg    <= meta_reg;
        end
    end

    assign q_o = q_reg;
endmodule

// ---- srse_next.sv ----
`timescale 1ns/1ns
// Next contents of the stage chain for load, shift and sign extend
module srse_next #(
    parameter int N = 8
) (
    // Present contents and data sources
    input  wire logic [N-1:0] stage_i,
    input  wire logic [N-1:0] par_i,
    input  wire logic         serial_in_0_i,
    input  wire logic         serial_in_1_i,
    // Mode selects
    input  wire logic         shift_or_load_i,
    input  wire logic         sign_extend_n_i,
    input  wire logic         data_select_i,
    // Result
    output logic      [N-1:0] next_o
);
    logic first_in;

    always_comb begin
        if (!sign_extend_n_i) begin
            first_in = stage_i[0];
        end else if (data_select_i) begin
            first_in = serial_in_1_i;
        end else begin
            first_in = serial_in_0_i;
        end
    end

    always_comb begin
        if (!shift_or_load_i) begin
            next_o = par_i;
        end else begin
            next_o = {stage_i[N-2:0], first_in};
        end
    end
endmodule

// ---- srse_host.sv ----
`timescale 1ns/1ns
// Host bus model: drives the terminals only when asked, else releases them
module srse_host (
    // Clock
    input  wire logic       sys_clk_i,
    // Host request
    input  wire logic       drive_i,
    input  wire logic [7:0] data_i,
    // Device side of the terminals
    input  wire logic [7:0] dev_data_i,
    input  wire logic [7:0] dev_oe_i,
    // Resolved terminal levels
    output logic      [7:0] bus_o
);
    logic [7:0] last_reg = 8'h00;

    // Released lines show the inverse of their last level, not a stale value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (dev_oe_i[i])
                bus_o[i] = dev_data_i[i];
            else if (drive_i)
                bus_o[i] = data_i[i];
            else
                bus_o[i] = ~last_reg[i];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        last_reg <= bus_o;
    end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic [4:0] ctrl;
        logic       s0;
        logic       s1;
        logic [7:0] pd;
        logic [7:0] exp;
    } srse_row_s;

    logic        sys_clk;
    logic        srst;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sclk;
    logic        clr_n;
    logic        si0;
    logic        si1;
    logic        hdrv;
    logic [7:0]  hdata;
    logic [7:0]  pio;
    logic [7:0]  pout;
    logic [7:0]  poe;
    logic        casc;
    logic [31:0] rd;
    logic        er;
    int          err_total = 0;
    int          num_checks = 0;
    srse_row_s   rows [9] = '{
        '{5'h04, 1'b0, 1'b0, 8'h96, 8'h96}, '{5'h06, 1'b1, 1'b0, 8'h00, 8'h2d},
        '{5'h0e, 1'b1, 1'b0, 8'h00, 8'h5a}, '{5'h02, 1'b0, 1'b1, 8'h00, 8'hb4},
        '{5'h0a, 1'b0, 1'b1, 8'h00, 8'h68}, '{5'h07, 1'b1, 1'b1, 8'h00, 8'h68},
        '{5'h05, 1'b1, 1'b0, 8'hff, 8'h68}, '{5'h14, 1'b0, 1'b0, 8'h81, 8'h81},
        '{5'h16, 1'b0, 1'b1, 8'h00, 8'h02}};

    srse_top dut (.sys_clk_i(sys_clk), .srst_i(srst), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .shift_clk_i(sclk),
        .async_clear_n_i(clr_n), .serial_in_0_i(si0), .serial_in_1_i(si1),
        .parallel_io_i(pio), .parallel_io_o(pout), .parallel_io_oe_o(poe),
        .cascade_out_o(casc));

    srse_host host (.sys_clk_i(sys_clk), .drive_i(hdrv), .data_i(hdata),
        .dev_data_i(pout), .dev_oe_i(poe), .bus_o(pio));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hung transfer
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        chk({31'h0, pslverr}, {31'h0, (a > srse_pkg::ADDR_STATUS)});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pin clock pulse, held long enough for the synchroniser
    task automatic step;
        @(posedge sys_clk);
        sclk <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sclk <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask

    function automatic logic [7:0] oe_of(input logic [4:0] c);
        return (!c[4] && (c[0] || c[1])) ? 8'hff : 8'h00;
    endfunction

    task automatic chk_state(input logic [7:0] e, input logic [7:0] oe);
        apb(1'b0, srse_pkg::ADDR_STAGES, 32'h0);
        chk(rd, {23'h0, e[7], e});
        chk({24'h0, pout}, {24'h0, e});
        chk({31'h0, casc}, {31'h0, e[7]});
        chk({24'h0, poe}, {24'h0, oe});
    endtask

    task automatic load(input logic [7:0] d);
        apb(1'b1, srse_pkg::ADDR_CTRL, 32'h04);
        hdrv <= 1'b1;
        hdata <= d;
        step();
    endtask

    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {sclk, clr_n, si0, si1, hdrv, hdata} = {5'b01000, 8'h00};
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b1, srse_pkg::ADDR_CTRL, {27'h0, rows[i].ctrl});
            si0 <= rows[i].s0;
            si1 <= rows[i].s1;
            hdata <= rows[i].pd;
            hdrv <= (rows[i].ctrl[1:0] == 2'b00);
            step();
            chk_state(rows[i].exp, oe_of(rows[i].ctrl));
        end
        repeat (10) @(posedge sys_clk);
        chk_state(8'h02, 8'h00);
        $display("test rows done");
        load(8'ha5);
        chk_state(8'ha5, 8'h00);
        apb(1'b1, srse_pkg::ADDR_CTRL, 32'h07);
        hdrv <= 1'b0;
        clr_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk_state(8'h00, 8'hff);
        load(8'h3c);
        chk_state(8'h00, 8'h00);
        clr_n <= 1'b1;
        $display("test clear done");
        apb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, srse_pkg::ADDR_STAGES, 32'hff);
        chk_state(8'h00, 8'h00);
        $display("test registers done");
        load(8'h3c);
        srst <= 1'b1;
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        apb(1'b0, srse_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h15);
        chk_state(8'h00, 8'h00);
        $display("test reset done");
        finish_test();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        finish_test();
    end
endmodule
